//--- bsd_pkg.sv
// bsd_pkg: shared types and constants for the burner status display selector
// assumes a single 50 MHz clock shared by the sequencer and this block
`default_nettype none
package bsd_pkg;

  // sequencer states, gray coded along the normal path
  typedef enum logic [2:0] {
    SEQ_STANDBY     = 3'h0,
    SEQ_PURGE       = 3'h1,
    SEQ_PREIGNITION = 3'h3,
    SEQ_FIRST_SAFE  = 3'h2,
    SEQ_PILOT_STABILIZATION  = 3'h6,
    SEQ_MAIN_TRIAL  = 3'h7,
    SEQ_RUN         = 3'h5,
    SEQ_POSTPURGE   = 3'h4
  } bsd_seq_e;

  // what the second line carries
  typedef enum logic {
    L2_SELECTABLE = 1'b0,
    L2_PREEMPTIVE = 1'b1
  } bsd_l2_e;

  // submenu tag in the right field of line one
  typedef enum logic [1:0] {
    TAG_BLANK     = 2'h0,
    TAG_DIAG_INFO = 2'h1,
    TAG_FAULT_HIS = 2'h2
  } bsd_tag_e;

  // field widths
  localparam int unsigned MSG_W     = 6;
  localparam int unsigned CAUSE_W   = 4;
  localparam int unsigned FCODE_W   = 8;
  localparam int unsigned ELAPSED_W = 16;
  localparam int unsigned MIN_W     = 11;
  localparam int unsigned SEC_W     = 6;
  localparam int unsigned HIST_W    = 3;

  // timing
  localparam int unsigned CLK_FREQ_KHZ      = 50000;
  localparam int unsigned SEC_TICK_MS       = 1000;
  localparam int unsigned SEC_TICK_CYCLES   = SEC_TICK_MS * CLK_FREQ_KHZ;
  localparam int unsigned SECS_PER_MIN      = 60;
  localparam logic [SEC_W-1:0] PREEMPT_TIMEOUT_S = 6'h3c;
  localparam logic [SEC_W-1:0] SEC_ZERO          = 6'h00;

endpackage
`default_nettype wire

//--- bsd_selector.sv
// bsd_selector: picks and formats line one, line two and the five lamps
// assumes sequencer inputs are on i_ref_clk; only the mode key is asynchronous
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - line one shows the present sequencer state out of the eight
// - purge, first safety, main trial, postpurge also show minutes and seconds
// - a held sequence shows state, hold marker and the cause code
// - lockout shows indication, fault code, fault message and fault state
// - right field is blank or arrow plus diagnostic or history tag
// - tag only while line two shows a submenu entry, else blank
// - preemptive and lockout messages on line two carry parentheses
// - a newly arising preemptive message replaces the selectable one
// - after 60 s a pending preemptive or lockout message displaces selection
// - pilot and main lamps follow the sequence state outside lockout, power stays lit, flame follows flame proven, alarm follows lockout
// - mode key jumps to preempted message, ignored when none exists
module bsd_selector #(
  parameter int unsigned SEC_CYCLES = bsd_pkg::SEC_TICK_CYCLES
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  input  wire bsd_pkg::bsd_seq_e             i_seq_state,
  input  wire logic [bsd_pkg::ELAPSED_W-1:0] i_elapsed_sec,
  input  wire logic                          i_seq_hold,
  input  wire logic [bsd_pkg::CAUSE_W-1:0]   i_hold_cause,
  input  wire logic                          i_lockout,
  input  wire logic [bsd_pkg::FCODE_W-1:0]   i_fault_code,
  input  wire logic [bsd_pkg::MSG_W-1:0]     i_fault_msg,
  input  wire bsd_pkg::bsd_seq_e             i_fault_state,
  input  wire logic                          i_flame_proven,
  input  wire logic                          i_submenu_active,
  input  wire logic                          i_submenu_history,
  input  wire logic [bsd_pkg::HIST_W-1:0]    i_history_index,
  input  wire logic [bsd_pkg::MSG_W-1:0]     i_sel_msg,
  input  wire logic                          i_pre_pending,
  input  wire logic [bsd_pkg::MSG_W-1:0]     i_pre_msg,
  input  wire logic                          i_mode_key,
  output logic                               o_l1_state_valid,
  output bsd_pkg::bsd_seq_e                  o_l1_state,
  output logic                               o_l1_show_time,
  output logic [bsd_pkg::MIN_W-1:0]          o_l1_minutes,
  output logic [bsd_pkg::SEC_W-1:0]          o_l1_seconds,
  output logic                               o_l1_hold,
  output logic [bsd_pkg::CAUSE_W-1:0]        o_l1_hold_code,
  output logic                               o_l1_lockout,
  output logic [bsd_pkg::FCODE_W-1:0]        o_l1_fault_code,
  output logic [bsd_pkg::MSG_W-1:0]          o_l1_fault_msg,
  output bsd_pkg::bsd_tag_e                  o_l1_tag,
  output logic [bsd_pkg::HIST_W-1:0]         o_l1_tag_num,
  output logic                               o_l2_paren,
  output logic [bsd_pkg::MSG_W-1:0]          o_l2_msg,
  output logic                               o_led_power,
  output logic                               o_led_pilot,
  output logic                               o_led_flame,
  output logic                               o_led_main,
  output logic                               o_led_alarm
);
  import bsd_pkg::*;

  // states whose elapsed time is shown
  function automatic logic is_timed(input bsd_seq_e s);
    is_timed = (s == SEQ_PURGE) || (s == SEQ_FIRST_SAFE) ||
               (s == SEQ_MAIN_TRIAL) || (s == SEQ_POSTPURGE);
  endfunction

  // states with the pilot lamp lit
  function automatic logic pilot_on(input bsd_seq_e s);
    pilot_on = (s == SEQ_FIRST_SAFE) || (s == SEQ_PILOT_STABILIZATION) ||
               (s == SEQ_MAIN_TRIAL);
  endfunction

  // states with the main lamp lit
  function automatic logic main_on(input bsd_seq_e s);
    main_on = (s == SEQ_MAIN_TRIAL) || (s == SEQ_RUN);
  endfunction

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
  localparam logic [ELAPSED_W-1:0] SECS_PER_MIN_W = ELAPSED_W'(SECS_PER_MIN);
  localparam logic [SEC_W-1:0]     SECS_PER_MIN_S = SEC_W'(SECS_PER_MIN);

  logic [31:0]        div_reg;
  logic               sec_tick;
  logic               mode_meta_reg;
  logic               mode_sync_reg;
  logic               mode_last_reg;
  logic               mode_pulse;
  logic               pend_last_reg;
  logic               avail;
  logic               arise;
  logic [MSG_W-1:0]   sel_last_reg;
  logic               sel_change;
  logic [SEC_W-1:0]   sel_sec_reg;
  logic               timeout;
  bsd_l2_e            l2_reg;
  bsd_l2_e            l2_next;
  logic [ELAPSED_W-1:0] min_full;
  logic [ELAPSED_W-1:0] sec_full;

  // one second enable
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= 32'h0;
    end else if (div_reg == SEC_LAST) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end
  assign sec_tick = (div_reg == SEC_LAST);

  // mode key synchroniser and edge
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
      mode_last_reg <= 1'b0;
    end else begin
      mode_meta_reg <= i_mode_key;
      mode_sync_reg <= mode_meta_reg;
      mode_last_reg <= mode_sync_reg;
    end
  end
  assign mode_pulse = mode_sync_reg & ~mode_last_reg;

  // event history for arising messages and selection changes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_last_reg <= 1'b0;
      sel_last_reg  <= '0;
    end else begin
      pend_last_reg <= avail;
      sel_last_reg  <= i_sel_msg;
    end
  end
  assign avail      = i_pre_pending | i_lockout;
  assign arise      = avail & ~pend_last_reg;
  assign sel_change = (i_sel_msg != sel_last_reg);

  // seconds the selectable message has been shown
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_sec_reg <= SEC_ZERO;
    end else if (l2_reg == L2_PREEMPTIVE || sel_change) begin
      sel_sec_reg <= SEC_ZERO;
    end else if (sec_tick && sel_sec_reg != PREEMPT_TIMEOUT_S) begin
      sel_sec_reg <= sel_sec_reg + 6'h1;
    end
  end
  assign timeout = (sel_sec_reg == PREEMPT_TIMEOUT_S);

  // second line source selection
  always_comb begin
    l2_next = l2_reg;
    if (!avail) begin
      l2_next = L2_SELECTABLE;
    end else if (arise) begin
      l2_next = L2_PREEMPTIVE;
    end else if (mode_pulse) begin
      l2_next = L2_PREEMPTIVE;
    end else if (sel_change) begin
      l2_next = L2_SELECTABLE;
    end else if (l2_reg == L2_SELECTABLE && timeout) begin
      l2_next = L2_PREEMPTIVE;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      l2_reg <= L2_SELECTABLE;
    end else begin
      l2_reg <= l2_next;
    end
  end

  // line two contents
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_l2_paren <= 1'b0;
      o_l2_msg   <= '0;
    end else begin
      unique case (l2_reg)
        L2_SELECTABLE: begin
          o_l2_paren <= 1'b0;
          o_l2_msg   <= i_sel_msg;
        end
        L2_PREEMPTIVE: begin
          o_l2_paren <= 1'b1;
          o_l2_msg   <= i_lockout ? i_fault_msg : i_pre_msg;
        end
      endcase
    end
  end

  // minutes and seconds split
  assign min_full = i_elapsed_sec / SECS_PER_MIN_W;
  assign sec_full = i_elapsed_sec % SECS_PER_MIN_W;

  // line one status fields
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_l1_state_valid <= 1'b0;
      o_l1_state       <= SEQ_STANDBY;
      o_l1_show_time   <= 1'b0;
      o_l1_minutes     <= '0;
      o_l1_seconds     <= '0;
      o_l1_hold        <= 1'b0;
      o_l1_hold_code   <= '0;
    end else begin
      o_l1_state_valid <= 1'b1;
      o_l1_state       <= i_lockout ? i_fault_state : i_seq_state;
      o_l1_show_time   <= !i_lockout && !i_seq_hold && is_timed(i_seq_state);
      o_l1_minutes     <= min_full[MIN_W-1:0];
      o_l1_seconds     <= sec_full[SEC_W-1:0];
      o_l1_hold        <= !i_lockout && i_seq_hold;
      o_l1_hold_code   <= i_seq_hold ? i_hold_cause : '0;
    end
  end

  // line one lockout fields
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_l1_lockout    <= 1'b0;
      o_l1_fault_code <= '0;
      o_l1_fault_msg  <= '0;
    end else begin
      o_l1_lockout    <= i_lockout;
      o_l1_fault_code <= i_lockout ? i_fault_code : '0;
      o_l1_fault_msg  <= i_lockout ? i_fault_msg : '0;
    end
  end

  // right field tag
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_l1_tag     <= TAG_BLANK;
      o_l1_tag_num <= '0;
    end else if (i_submenu_active && l2_reg == L2_SELECTABLE) begin
      o_l1_tag     <= i_submenu_history ? TAG_FAULT_HIS : TAG_DIAG_INFO;
      o_l1_tag_num <= i_submenu_history ? i_history_index : '0;
    end else begin
      o_l1_tag     <= TAG_BLANK;
      o_l1_tag_num <= '0;
    end
  end

  // sequence lamps
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_led_power <= 1'b0;
      o_led_pilot <= 1'b0;
      o_led_flame <= 1'b0;
      o_led_main  <= 1'b0;
      o_led_alarm <= 1'b0;
    end else begin
      o_led_power <= 1'b1;
      o_led_pilot <= !i_lockout && pilot_on(i_seq_state);
      o_led_flame <= i_flame_proven;
      o_led_main  <= !i_lockout && main_on(i_seq_state);
      o_led_alarm <= i_lockout;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  state_shown_a: assert property (
    !$past(i_lockout) && !$past(i_rst) |-> o_l1_state == $past(i_seq_state))
    else $error("line one state does not follow sequencer");
  time_format_a: assert property (
    o_l1_show_time |-> is_timed(o_l1_state) && o_l1_seconds < SECS_PER_MIN_S)
    else $error("timing shown in wrong state or bad seconds");
  hold_marker_a: assert property (
    i_seq_hold && !i_lockout |=> o_l1_hold && o_l1_hold_code == $past(i_hold_cause))
    else $error("hold marker or cause missing");
  lockout_info_a: assert property (
    i_lockout |=> o_l1_lockout && o_l1_fault_code == $past(i_fault_code) && o_led_alarm)
    else $error("lockout information missing");
  tag_blank_a: assert property (
    !(i_submenu_active && l2_reg == L2_SELECTABLE) |=> o_l1_tag == TAG_BLANK)
    else $error("tag shown without submenu entry");
  tag_kind_a: assert property (
    i_submenu_active && l2_reg == L2_SELECTABLE |=>
      o_l1_tag == ($past(i_submenu_history) ? TAG_FAULT_HIS : TAG_DIAG_INFO))
    else $error("wrong submenu tag");
  paren_mark_a: assert property (
    l2_reg == L2_PREEMPTIVE ##1 l2_reg == L2_PREEMPTIVE |-> o_l2_paren)
    else $error("preemptive message without parentheses");
  arise_preempt_a: assert property (
    arise |=> l2_reg == L2_PREEMPTIVE ##1 o_l2_paren)
    else $error("arising message did not preempt");
  timeout_preempt_a: assert property (
    l2_reg == L2_SELECTABLE && timeout && avail && !sel_change |=> l2_reg == L2_PREEMPTIVE)
    else $error("timeout did not preempt");
  stays_sel_a: assert property (
    l2_reg == L2_SELECTABLE && !avail |=> l2_reg == L2_SELECTABLE)
    else $error("selection left with nothing pending");
  mode_key_a: assert property (
    mode_pulse && avail |=> l2_reg == L2_PREEMPTIVE)
    else $error("mode key not honoured");
  timer_clear_a: assert property (
    l2_reg == L2_PREEMPTIVE || sel_change |=> sel_sec_reg == SEC_ZERO)
    else $error("timeout counter not cleared");
  main_lamp_a: assert property (
    o_led_main |-> $past(main_on(i_seq_state)) && !o_led_alarm)
    else $error("main lamp outside main trial or run");

  timeout_c: cover property (
    l2_reg == L2_SELECTABLE && timeout && avail ##1 l2_reg == L2_PREEMPTIVE);
  mode_c: cover property (mode_pulse && avail && l2_reg == L2_SELECTABLE);
  lockout_c: cover property (i_lockout ##2 o_l2_paren);
  tag_c: cover property (o_l1_tag == TAG_FAULT_HIS);

endmodule

`default_nettype wire

//--- bsd_seq_model.sv
// bsd_seq_model: behavioural sequencer feeding the selector's sequence inputs
// assumes bench requests arrive just after a rising edge and show one edge later
`timescale 1ns/1ps
`default_nettype none
module bsd_seq_model (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  input  wire bsd_pkg::bsd_seq_e             i_go_state,
  input  wire logic [bsd_pkg::ELAPSED_W-1:0] i_go_elapsed,
  input  wire logic                          i_go_hold,
  input  wire logic [bsd_pkg::CAUSE_W-1:0]   i_go_cause,
  input  wire logic                          i_go_lock,
  output bsd_pkg::bsd_seq_e                  o_seq_state,
  output logic [bsd_pkg::ELAPSED_W-1:0]      o_elapsed_sec,
  output logic                               o_seq_hold,
  output logic [bsd_pkg::CAUSE_W-1:0]        o_hold_cause,
  output logic                               o_lockout,
  output bsd_pkg::bsd_seq_e                  o_fault_state
);
  import bsd_pkg::*;
  // state, timing and hold follow the request
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_seq_state   <= SEQ_STANDBY;
      o_elapsed_sec <= '0;
      o_seq_hold    <= 1'b0;
      o_hold_cause  <= '0;
    end else begin
      o_seq_state   <= i_go_state;
      o_elapsed_sec <= i_go_elapsed;
      o_seq_hold    <= i_go_hold;
      o_hold_cause  <= i_go_hold ? i_go_cause : '0;
    end
  end
  // fault state latched as lockout begins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lockout     <= 1'b0;
      o_fault_state <= SEQ_STANDBY;
    end else begin
      o_lockout <= i_go_lock;
      if (i_go_lock && !o_lockout) begin
        o_fault_state <= i_go_state;
      end
    end
  end
endmodule
`default_nettype wire

//--- test_burner_status_display_selector.sv
// test_burner_status_display_selector: scoreboarded bench for bsd_selector
// assumes bsd_seq_model as sequencer and a four-cycle second tick
`timescale 1ns/1ps
`default_nettype none
module test_burner_status_display_selector;
  import bsd_pkg::*;
  logic clk, rst, hold, lock, flame, sub, hist, pend, key, hd, lk;
  bsd_seq_e st, fs, ms, mfs, o_st;
  logic [15:0] el, mel;
  logic [3:0] cause, mc, o_code;
  logic [7:0] fcode, o_fc;
  logic [5:0] fmsg, sel, pmsg, o_fm, o_msg, o_sec;
  logic [2:0] hidx, o_num;
  logic [10:0] o_min;
  bsd_tag_e o_tag;
  logic o_v, o_show, o_hold, o_lock, o_paren, o_pw, o_pi, o_fl, o_mn, o_al;
  logic [58:0] q[$];
  int failures, comparisons;
  event chk;

  bsd_seq_model model (.i_ref_clk(clk), .i_rst(rst), .i_go_state(st), .i_go_elapsed(el),
    .i_go_hold(hold), .i_go_cause(cause), .i_go_lock(lock), .o_seq_state(ms),
    .o_elapsed_sec(mel), .o_seq_hold(hd), .o_hold_cause(mc), .o_lockout(lk),
    .o_fault_state(mfs));
  bsd_selector #(.SEC_CYCLES(4)) uut (.i_ref_clk(clk), .i_rst(rst), .i_seq_state(ms),
    .i_elapsed_sec(mel), .i_seq_hold(hd), .i_hold_cause(mc), .i_lockout(lk),
    .i_fault_code(fcode), .i_fault_msg(fmsg), .i_fault_state(mfs), .i_flame_proven(flame),
    .i_submenu_active(sub), .i_submenu_history(hist), .i_history_index(hidx),
    .i_sel_msg(sel), .i_pre_pending(pend), .i_pre_msg(pmsg), .i_mode_key(key),
    .o_l1_state_valid(o_v), .o_l1_state(o_st), .o_l1_show_time(o_show),
    .o_l1_minutes(o_min), .o_l1_seconds(o_sec), .o_l1_hold(o_hold),
    .o_l1_hold_code(o_code), .o_l1_lockout(o_lock), .o_l1_fault_code(o_fc),
    .o_l1_fault_msg(o_fm), .o_l1_tag(o_tag), .o_l1_tag_num(o_num), .o_l2_paren(o_paren),
    .o_l2_msg(o_msg), .o_led_power(o_pw), .o_led_pilot(o_pi), .o_led_flame(o_fl),
    .o_led_main(o_mn), .o_led_alarm(o_al));

  function automatic logic [58:0] pk(bsd_seq_e s, logic t, logic [10:0] m, logic [5:0] c,
      logic h, logic [3:0] hc, logic l, logic [7:0] f, logic [5:0] fm, bsd_tag_e g,
      logic [2:0] n, logic p, logic [5:0] msg, logic [5:0] led);
    return {s, t, t ? {m, c} : 17'h0, h, hc, l, f, fm, g, n, p, msg, led};
  endfunction

  function automatic logic [58:0] ex(logic p);
    logic tm;
    logic tg;
    tm = st inside {SEQ_PURGE, SEQ_FIRST_SAFE, SEQ_MAIN_TRIAL, SEQ_POSTPURGE} && !hold && !lock;
    tg = sub && !p;
    return pk(lock ? fs : st, tm, 11'(el / 60), 6'(el % 60), hold, hold ? cause : 4'h0,
      lock, lock ? fcode : 8'h0, lock ? fmsg : 6'h0,
      tg ? (hist ? TAG_FAULT_HIS : TAG_DIAG_INFO) : TAG_BLANK, (tg && hist) ? hidx : 3'h0,
      p, p ? (lock ? fmsg : pmsg) : sel,
      {2'b11, !lock && st inside {SEQ_FIRST_SAFE, SEQ_PILOT_STABILIZATION, SEQ_MAIN_TRIAL}, flame,
       !lock && st inside {SEQ_MAIN_TRIAL, SEQ_RUN}, lock});
  endfunction

  task automatic settle(logic p, int n);
    repeat (n + 6) @(posedge clk);
    #1;
    q.push_back(ex(p));
    -> chk;
  endtask

  task automatic done(string s);
    $display("test %s finished", s);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // scoreboard: oldest note against the outputs
  always @(chk) begin
    logic [58:0] e, g;
    e = q.pop_front();
    g = pk(o_st, o_show, o_min, o_sec, o_hold, o_code, o_lock, o_fc, o_fm, o_tag, o_num,
      o_paren, o_msg, {o_v, o_pw, o_pi, o_fl, o_mn, o_al});
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: display mismatch got %h want %h", $time, g, e);
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #(4000 * 20);
    failures++;
    wrap_up();
  end

  initial begin
    void'($urandom(49520));
    {rst, hold, lock, flame, sub, hist, pend, key} = 8'h80;
    {el, cause, fcode, fmsg, sel, pmsg, hidx} = '0;
    st = SEQ_STANDBY;
    fs = SEQ_STANDBY;
    repeat (8) @(posedge clk);
    #1;
    q.push_back(59'h0);
    -> chk;
    rst = 1'b0;
    st = st.first();
    repeat (8) begin
      el = 16'($urandom_range(7200));
      flame = 1'($urandom);
      settle(0, 0);
      st = st.next();
    end
    done("states");
    st = SEQ_PURGE;
    hold = 1'b1;
    cause = 4'($urandom);
    settle(0, 0);
    hold = 1'b0;
    sub = 1'b1;
    settle(0, 0);
    hist = 1'b1;
    hidx = 3'($urandom);
    settle(0, 0);
    done("line one");
    pend = 1'b1;
    pmsg = 6'($urandom);
    settle(1, 0);
    sel = sel ^ (6'h01 | 6'($urandom));
    settle(0, 0);
    key = 1'b1;
    settle(1, 0);
    key = 1'b0;
    pend = 1'b0;
    settle(0, 0);
    key = 1'b1;
    settle(0, 0);
    key = 1'b0;
    done("mode key");
    pend = 1'b1;
    settle(1, 0);
    sel = sel ^ (6'h01 | 6'($urandom));
    settle(0, 194);
    sel = sel ^ (6'h01 | 6'($urandom));
    settle(0, 219);
    settle(1, 30);
    done("timeout");
    pend = 1'b0;
    settle(0, 0);
    st = SEQ_RUN;
    fs = SEQ_RUN;
    lock = 1'b1;
    fcode = 8'($urandom);
    fmsg = 6'($urandom);
    settle(1, 0);
    lock = 1'b0;
    settle(0, 0);
    done("lockout");
    settle(0, 250);
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    q.push_back(59'h0);
    -> chk;
    rst = 1'b0;
    settle(0, 0);
    done("idle and reset");
    wrap_up();
  end
endmodule
`default_nettype wire
